/* File: src/fault_pkg.sv */
package fault_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
  localparam int unsigned CP_UV_FILT_NS     = 10_000;
  localparam int unsigned CP_UV_FILT_CYC    = (CP_UV_FILT_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
  localparam int unsigned SVC_FLAG_W        = 16;
  localparam int unsigned BIT_PUMP_VDS      = 11;
  localparam int unsigned BIT_CP_UV         = 3;
  localparam logic        OUT_CFG_RESET     = 1'b0;
  localparam logic [15:0] SVC_FLAGS_RESET   = 16'h0000;
  typedef enum logic {MODE_IRQ, MODE_LED} out_mode_t;
endpackage : fault_pkg

/* File: src/flag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface flag_if;
  logic set;
  logic clr;
  logic flag;
  modport owner (input set, input clr, output flag);
  modport user  (output set, output clr, input flag);
endinterface : flag_if
`default_nettype wire

/* File: src/sticky_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  flag_if.owner     f
);
  logic flag_q;
  logic flag_d;
  // Set beats clear so a fault in the read cycle survives
  assign flag_d = f.set | (flag_q & ~f.clr);
  assign f.flag = flag_q;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end
endmodule : sticky_flag
`default_nettype wire

/* File: src/glitch_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
#(
  parameter int unsigned CYCLES = 1000
)
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic raw_in,
  output logic      accepted
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          hit;
  assign hit   = (cnt_q == CW'(CYCLES - 1));
  assign cnt_d = !raw_in ? '0 : (hit ? cnt_q : cnt_q + CW'(1));
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
  assign accepted = raw_in & hit;
endmodule : glitch_filter
`default_nettype wire

/* File: src/fault_handling_and_irq_output.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] A pump drain-source fault while the pump runs in PWM mode blocks the pump PWM and sets flag bit 11.
// [RQ2] The pump fault flag clears on host read and the pump PWM then resumes by itself.
// [RQ3] A charge-pump undervoltage sets a latched readable flag.
// [RQ4] The undervoltage monitor is never masked, also during power-up.
// [RQ5] The undervoltage comparator must stay active for 10 us before the fault counts.
// [RQ6] An accepted undervoltage disables all solenoid outputs and the pump and sets flag bit 3.
// [RQ7] After undervoltage the host re-enables the channel, pump and driver enables; the flag clears on read.
// [RQ8] One open-drain output acts as interrupt or plain output, chosen by a configuration bit.
// [RQ9] After reset the configuration bit is 0, selecting interrupt mode.
// [RQ10] In interrupt mode a pending interrupt drives the pin low.
// [RQ11] With configuration 1 the pin is an LED driver following a host command bit.
// [RQ12] In LED mode off-state open-load and short-to-ground checks run; open load may be disabled.
// [RQ13] An on-state overcurrent turns the output off at once and latches a fault cleared by read.
// [RQ14] The output stays off until the overcurrent fault clears, then restarts in its mode.
// [RQ15] The pump fault raises the interrupt only when its mask bit is 0.
// [RQ16] Each fault source can be masked from raising the interrupt.
// [RQ17] The interrupt pin releases once no unmasked latched fault and no unmasked ext_fault remain.
module fault_handling_and_irq_output
  import fault_pkg::*;
#(
  parameter int unsigned N_SOL     = 6,
  parameter int unsigned UV_CYCLES = CP_UV_FILT_CYC
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             pump_enable,
  input  wire logic             pump_pwm_in,
  input  wire logic             pump_vds_fault,
  input  wire logic             cp_uv_raw,
  input  wire logic             out_config,
  input  wire logic             led_cmd,
  input  wire logic             open_load_check_en,
  input  wire logic             out_overcurrent,
  input  wire logic             out_open_load_raw,
  input  wire logic             out_short_gnd_raw,
  input  wire logic             pump_vds_irq_mask,
  input  wire logic             cp_uv_irq_mask,
  input  wire logic             out_oc_irq_mask,
  input  wire logic             out_diag_irq_mask,
  input  wire logic             ext_fault,
  input  wire logic             ext_fault_mask,
  input  wire logic             flags_read,
  input  wire logic             diag_read,
  input  wire logic [N_SOL-1:0] solenoid_channel_enable_set,
  input  wire logic             pump_enable_set,
  input  wire logic             solenoid_driver_enable_set,
  output logic [N_SOL-1:0]      solenoid_channel_enable,
  output logic                  pump_predriver_en,
  output logic                  solenoid_driver_enable,
  output logic                  pump_pwm_out,
  output logic [SVC_FLAG_W-1:0] service_fault_flags,
  output logic                  out_oc_flag,
  output logic                  out_open_load_flag,
  output logic                  out_short_gnd_flag,
  output logic                  out_bias_en,
  output logic                  fault_signal_output_o,
  output logic                  fault_signal_output_oe_n,
  output logic                  irq_pending
);
  flag_if f_vds ();
  flag_if f_uv ();
  flag_if f_oc ();
  flag_if f_ol ();
  flag_if f_sg ();

  logic                  uv_accepted;
  logic                  mode_led;
  logic                  drive_req;
  logic                  drive_on;
  logic                  irq_any;
  logic [N_SOL-1:0]      sol_en_q;
  logic [N_SOL-1:0]      sol_en_d;
  logic                  pump_en_q;
  logic                  pump_en_d;
  logic                  drv_en_q;
  logic                  drv_en_d;
  logic                  pwm_q;
  logic                  oe_n_q;
  logic [SVC_FLAG_W-1:0] flags_d;
  logic                  irq_vds;
  logic                  irq_uv;
  logic                  irq_oc;
  logic                  irq_diag;
  logic                  irq_ext;
  out_mode_t             out_mode;

  // Run length of the raw comparator, for the filter checks below
  localparam int unsigned         UV_RUN_W   = $clog2(UV_CYCLES + 1);
  localparam logic [UV_RUN_W-1:0] UV_RUN_MAX = UV_RUN_W'(UV_CYCLES);
  localparam logic [UV_RUN_W-1:0] UV_RUN_MIN = UV_RUN_W'(UV_CYCLES - 1);
  logic [UV_RUN_W-1:0]   uv_run_q;
  logic [UV_RUN_W-1:0]   uv_run_d;

  // Filter never gated by power-up state
  glitch_filter #(.CYCLES(UV_CYCLES)) u_uv_filt
  (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .raw_in   (cp_uv_raw),
    .accepted (uv_accepted)
  ); // RQ4 RQ5

  sticky_flag u_vds
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (f_vds)
  );

  sticky_flag u_uv
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (f_uv)
  );

  sticky_flag u_oc
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (f_oc)
  );

  sticky_flag u_ol
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (f_ol)
  );

  sticky_flag u_sg
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (f_sg)
  );

  assign f_vds.set = pump_vds_fault & pump_en_q & pump_enable; // RQ1
  assign f_vds.clr = flags_read; // RQ2
  assign f_uv.set  = uv_accepted; // RQ3
  assign f_uv.clr  = flags_read; // RQ7
  assign out_mode  = out_mode_t'(out_config); // RQ9
  assign mode_led  = (out_mode == MODE_LED); // RQ8 RQ11
  assign drive_req = mode_led ? led_cmd : irq_any; // RQ10 RQ11
  // Overcurrent only exists while the switch conducts
  assign f_oc.set  = out_overcurrent & drive_on; // RQ13
  assign f_oc.clr  = diag_read;
  assign f_ol.set  = mode_led & ~drive_req & open_load_check_en & out_open_load_raw; // RQ12
  assign f_ol.clr  = diag_read;
  assign f_sg.set  = mode_led & ~drive_req & out_short_gnd_raw; // RQ12
  assign f_sg.clr  = diag_read;

  // Masked flags still latch, they only stay off the pin
  assign irq_vds  = f_vds.flag & ~pump_vds_irq_mask; // RQ15
  assign irq_uv   = f_uv.flag & ~cp_uv_irq_mask; // RQ16
  assign irq_oc   = f_oc.flag & ~out_oc_irq_mask; // RQ16
  assign irq_diag = (f_ol.flag | f_sg.flag) & ~out_diag_irq_mask; // RQ16
  assign irq_ext  = ext_fault & ~ext_fault_mask; // RQ16
  assign irq_any  = irq_vds | irq_uv | irq_oc | irq_diag | irq_ext; // RQ17
  assign drive_on = drive_req & ~f_oc.flag; // RQ13 RQ14

  // Host re-enable only, nothing restarts from undervoltage alone
  assign sol_en_d  = uv_accepted ? '0 : (sol_en_q | solenoid_channel_enable_set); // RQ6 RQ7
  assign pump_en_d = uv_accepted ? 1'b0 : (pump_en_q | pump_enable_set); // RQ6 RQ7
  assign drv_en_d  = uv_accepted ? 1'b0 : (drv_en_q | solenoid_driver_enable_set); // RQ6 RQ7

  always_comb
  begin
    flags_d = SVC_FLAGS_RESET;
    flags_d[BIT_PUMP_VDS] = f_vds.flag; // RQ1
    flags_d[BIT_CP_UV]    = f_uv.flag; // RQ6
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sol_en_q  <= '0;
      pump_en_q <= 1'b0;
      drv_en_q  <= 1'b0;
      pwm_q     <= 1'b0;
      oe_n_q    <= 1'b1;
    end
    else
    begin
      sol_en_q  <= sol_en_d;
      pump_en_q <= pump_en_d;
      drv_en_q  <= drv_en_d;
      pwm_q     <= pump_enable & pump_en_q & pump_pwm_in & ~f_vds.flag; // RQ1 RQ2
      oe_n_q    <= ~drive_on | f_oc.set; // RQ10 RQ13
    end
  end

  // Checker aid only, saturating so it never wraps on a long dip
  assign uv_run_d = !cp_uv_raw ? '0
                  : (uv_run_q == UV_RUN_MAX ? uv_run_q : uv_run_q + UV_RUN_W'(1));

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      uv_run_q <= '0;
    else
      uv_run_q <= uv_run_d;
  end

  // Open-drain: output value is always low, enable is active low
  assign fault_signal_output_o    = 1'b0;
  assign fault_signal_output_oe_n = oe_n_q;
  assign solenoid_channel_enable  = sol_en_q;
  assign pump_predriver_en        = pump_en_q;
  assign solenoid_driver_enable   = drv_en_q;
  assign pump_pwm_out             = pwm_q;
  assign service_fault_flags      = flags_d;
  assign out_oc_flag              = f_oc.flag;
  assign out_open_load_flag       = f_ol.flag;
  assign out_short_gnd_flag       = f_sg.flag;
  assign out_bias_en              = mode_led & open_load_check_en; // RQ12
  assign irq_pending              = irq_any;

  a_pwm_blocked: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ1
    f_vds.flag |=> !pump_pwm_out)
    else $error("pump pwm active with vds flag");

  a_vds_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ1
    (pump_vds_fault && pump_enable && pump_predriver_en) |=> service_fault_flags[BIT_PUMP_VDS])
    else $error("vds flag not set");

  a_vds_clears: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ2
    (flags_read && !f_vds.set) |=> !service_fault_flags[BIT_PUMP_VDS])
    else $error("vds flag not cleared on read");

  a_vds_resume: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ2
    (!f_vds.flag && pump_enable && pump_predriver_en && pump_pwm_in) |=> pump_pwm_out)
    else $error("pump pwm did not resume");

  a_uv_latch: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ3
    uv_accepted |=> service_fault_flags[BIT_CP_UV])
    else $error("uv flag not set");

  a_uv_no_mask: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ4
    (cp_uv_raw && uv_run_q >= UV_RUN_MIN) |-> uv_accepted)
    else $error("uv filter gated");

  a_uv_filter: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ5
    $rose(uv_accepted) |-> $past(cp_uv_raw, 2))
    else $error("uv accepted too early");

  a_uv_min_time: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ5
    uv_accepted |-> (uv_run_q >= UV_RUN_MIN))
    else $error("uv accepted before filter time");

  a_uv_shutdown: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ6
    uv_accepted |=> (!pump_predriver_en && solenoid_channel_enable == '0
      && !solenoid_driver_enable))
    else $error("outputs not disabled on uv");

  a_uv_pwm_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ6
    uv_accepted |-> ##2 !pump_pwm_out)
    else $error("pump pwm active after uv");

  a_reset_release: assert property (@(posedge clk_sys) // RQ9
    !reset_n |=> fault_signal_output_oe_n)
    else $error("pin driven after reset");

  a_irq_pin_low: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ10
    (!out_config && irq_any && !f_oc.flag && !out_overcurrent) |=> !fault_signal_output_oe_n)
    else $error("irq not driven");

  a_led_follow: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ11
    (out_config && !f_oc.flag && !out_overcurrent)
      |=> (fault_signal_output_oe_n == !$past(led_cmd)))
    else $error("led does not follow command");

  a_ol_gated: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ12
    (!open_load_check_en && !out_open_load_flag) |=> !out_open_load_flag)
    else $error("open load flagged while disabled");

  a_sg_active: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ12
    (out_config && !led_cmd && out_short_gnd_raw) |=> out_short_gnd_flag)
    else $error("short to ground not flagged");

  a_oc_latch: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ13
    f_oc.set |=> (out_oc_flag && fault_signal_output_oe_n))
    else $error("overcurrent not handled");

  a_oc_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ14
    f_oc.flag |=> fault_signal_output_oe_n)
    else $error("output on during oc");

  a_oc_restart: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ14
    ($fell(out_oc_flag) && out_config && led_cmd && !out_overcurrent) |=> !fault_signal_output_oe_n)
    else $error("output did not restart");

  a_vds_mask: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ15
    (f_vds.flag && !pump_vds_irq_mask) |-> irq_pending)
    else $error("vds irq lost");

  a_uv_irq: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ16
    (service_fault_flags[BIT_CP_UV] && !cp_uv_irq_mask) |-> irq_pending)
    else $error("uv irq lost");

  a_oc_irq: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ16
    (out_oc_flag && !out_oc_irq_mask) |-> irq_pending)
    else $error("oc irq lost");

  a_irq_release: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ17
    (!out_config && !irq_any) |=> fault_signal_output_oe_n)
    else $error("pin not released");
endmodule : fault_handling_and_irq_output
`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
  parameter int unsigned NS    = 6,
  parameter int unsigned DELAY = 8
)
(
  input  wire logic          clk_sys,
  input  wire logic          pin,
  input  wire logic          auto_en,
  input  wire logic          read_now,
  input  wire logic [15:0]   flags,
  input  wire logic [NS-1:0] chan_sel,
  output logic               rd_pulse = 1'h0,
  output logic               en_set = 1'h0,
  output logic [NS-1:0]      chan_set = '0
);
  int       wait_q = 0;
  logic     reen_q = 1'h0;
  wire logic low = auto_en && !pin;
  wire logic go  = low && wait_q == DELAY;
  // Firmware latency: a low pin is served only after DELAY cycles
  always @(posedge clk_sys)
  begin
    en_set   <= reen_q;
    chan_set <= reen_q ? chan_sel : '0;
    rd_pulse <= read_now || go;
    reen_q   <= read_now || (go && flags[3]);
    wait_q   <= (low && wait_q < DELAY) ? wait_q + 1 : 0;
  end
endmodule : host_model
`default_nettype wire

/* File: bench/tb_fault_handling_and_irq_output.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fault_handling_and_irq_output;
  import fault_pkg::*;
  localparam int UVC = 4;
  logic clk_sys = 0, reset_n = 0, pen = 0, pwm = 1, vds = 0, uv = 0, cfg = 0, led = 0;
  logic ol_en = 0, oc = 0, ol = 0, sg = 0, vm = 0, xf = 0, xm = 0, auto_en = 1, rd = 0;
  logic um = 0, om = 0, dm = 0;
  logic rdp, ens, en_p, en_d, pwm_o, ocf, olf, sgf, bias, o, oe_n, irq;
  logic [5:0]  ces, en_c, chan = '0;
  logic [15:0] flags;
  logic [31:0] rs = 32'h0000AF1D;
  int num_errors = 0;
  int total_checks = 0;
  wire logic pin = oe_n ? 1'h1 : o; // Pull-up holds a released pin high
  fault_handling_and_irq_output #(.N_SOL(6), .UV_CYCLES(UVC)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .pump_enable(pen), .pump_pwm_in(pwm),
    .pump_vds_fault(vds), .cp_uv_raw(uv), .out_config(cfg), .led_cmd(led),
    .open_load_check_en(ol_en), .out_overcurrent(oc), .out_open_load_raw(ol),
    .out_short_gnd_raw(sg), .pump_vds_irq_mask(vm), .cp_uv_irq_mask(um),
    .out_oc_irq_mask(om), .out_diag_irq_mask(dm), .ext_fault(xf), .ext_fault_mask(xm),
    .flags_read(rdp), .diag_read(rdp), .solenoid_channel_enable_set(ces),
    .pump_enable_set(ens), .solenoid_driver_enable_set(ens), .solenoid_channel_enable(en_c),
    .pump_predriver_en(en_p), .solenoid_driver_enable(en_d), .pump_pwm_out(pwm_o),
    .service_fault_flags(flags), .out_oc_flag(ocf), .out_open_load_flag(olf),
    .out_short_gnd_flag(sgf), .out_bias_en(bias), .fault_signal_output_o(o),
    .fault_signal_output_oe_n(oe_n), .irq_pending(irq));
  host_model #(.NS(6), .DELAY(8)) host (.clk_sys(clk_sys), .pin(pin), .auto_en(auto_en),
    .read_now(rd), .flags(flags), .chan_sel(chan), .rd_pulse(rdp), .en_set(ens),
    .chan_set(ces));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic serve;
    rd = 1;
    tick(1);
    rd = 0;
    tick(5);
  endtask : serve
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end
  initial
  begin
    tick(4);
    reset_n = 1;
    chk("oe_n", oe_n, 1);
    // Pass 0 is one edge short of the filter, pass 1 lands before any enable
    for (int k = 0; k < 3; k++)
    begin
      rs = xs(rs);
      chan = rs[5:0] | 6'h01;
      uv = 1;
      tick(k ? UVC + 1 : UVC - 1);
      uv = 0;
      tick(2);
      chk("flags", flags, k ? 16'h0008 : 16'h0000);
      if (k != 0)
      begin
        chk("oe_n", oe_n, 0);
        chk("en", {en_c, en_p, en_d}, 0);
        tick(24);
        chk("flags", flags, 0);
        chk("en", {en_c, en_p, en_d}, {chan, 2'h3});
        chk("oe_n", oe_n, 1);
      end
    end
    // Masked undervoltage still latches and shuts down, but keeps the pin quiet
    um = 1;
    uv = 1;
    tick(UVC + 1);
    uv = 0;
    tick(2);
    chk("flags", flags, 16'h0008);
    chk("irq", irq, 0);
    chk("oe_n", oe_n, 1);
    chk("en", {en_c, en_p, en_d}, 0);
    serve();
    chk("flags", flags, 0);
    chk("en", {en_c, en_p, en_d}, {chan, 2'h3});
    um = 0;
    pen = 1;
    pwm = 0;
    tick(2);
    chk("pwm", pwm_o, 0);
    pwm = 1;
    tick(2);
    chk("pwm", pwm_o, 1);
    for (int m = 0; m < 2; m++)
    begin
      vm = m[0];
      vds = 1;
      tick(1);
      vds = 0;
      tick(2);
      chk("flags", flags, 16'h0800);
      chk("pwm", pwm_o, 0);
      chk("oe_n", oe_n, m[0]);
      chk("irq", irq, !m[0]);
      if (m == 1) serve();
      else tick(24);
      chk("flags", flags, 0);
      chk("pwm", pwm_o, 1);
    end
    xf = 1;
    tick(2);
    chk("oe_n", oe_n, 0);
    xm = 1;
    tick(2);
    chk("oe_n", oe_n, 1);
    auto_en = 0;
    cfg = 1;
    repeat (16)
    begin
      rs = xs(rs);
      {led, ol_en} = rs[1:0];
      tick(2);
      chk("oe_n", oe_n, !led);
      chk("bias", bias, ol_en);
    end
    {led, ol_en, ol, sg} = 4'h3;
    tick(3);
    chk("diag", {olf, sgf}, 2'h1);
    ol_en = 1;
    tick(3);
    chk("diag", {olf, sgf}, 2'h3);
    chk("irq", irq, 1);
    dm = 1;
    tick(1);
    chk("irq", irq, 0);
    dm = 0;
    {led, ol, sg} = 3'h4;
    serve();
    chk("diag", {olf, sgf}, 2'h0);
    oc = 1;
    tick(2);
    chk("oc", {oe_n, ocf}, 2'h3);
    chk("irq", irq, 1);
    oc = 0;
    om = 1;
    tick(3);
    chk("oe_n", oe_n, 1);
    chk("irq", irq, 0);
    om = 0;
    serve();
    chk("oc", {oe_n, ocf}, 2'h0);
    conclude();
  end
endmodule : tb_fault_handling_and_irq_output
`default_nettype wire
